// >>> inc/agts_consts.vh
// Purpose: constants of the gate turn-off sequencer
// Assumes: included by src/agts_top.v
// Notes: register map and field positions
`ifndef AGTS_CONSTS_VH
`define AGTS_CONSTS_VH
// ==========================================
// Register byte offsets
`define AGTS_OFF_CTRL 8'h00
`define AGTS_OFF_CURR 8'h04
`define AGTS_OFF_TIME 8'h08
`define AGTS_OFF_TGT 8'h0c
`define AGTS_OFF_TIME2 8'h10
`define AGTS_OFF_STAT 8'h14
// ==========================================
// Control fields
`define AGTS_MODE_LO 0
`define AGTS_FILT_BIT 2
`define AGTS_STEP_BIT 3
`define AGTS_AFW_BIT 4
`define AGTS_EN_BIT 5
`define AGTS_TM_BIT 6
`define AGTS_MAPLS_BIT 7
// ==========================================
// Reset values
`define AGTS_CTRL_RST 8'h00
`define AGTS_CURR_RST 32'h3f3f_3f20
`define AGTS_TIME_RST 32'h0a08_2004
`define AGTS_TGT_RST 16'h1010
`define AGTS_TIME2_RST 16'h1004
// ==========================================
// Current step minimum and regulation limits
`define AGTS_CUR_MIN 6'h00
`define AGTS_REG_CNT 4'h8
`define AGTS_SIGN_CHG 2'h3
`endif

// >>> src/agts_top.v
// Purpose: adaptive half-bridge turn-off sequencer with APB registers
// Assumes: PWM and comparator inputs synchronous to REF_CLK
// Notes: all times in REF_CLK cycles
// Contract
// - Delay turn-off by freewheel cross-conduction time
// - Then pre-discharge with adaptive current
// - Then discharge current, measure turn-off delay
// - Discharge ends when active interval expires
// - Active interval concurrent, complementary switch off
// - Then freewheel charge until filter, node low
// - Adapt only in the two adaptive modes
// - Clamp current between minimum and maximum
// - Enable write loads min(initial, maximum)
// - Step size one or two
// - Unfiltered: raise if long, lower if short
// - Filtered: change only on two alike
// - Measured turn-off delay is readable
// - Passive freewheel keeps complementary switch off
// - Passive: no interval at rising edge
// - Passive: interval at falling edge, as in active mode
// - Low-side mapping swaps switches and thresholds
// - One in-regulation flag in adaptive mode
// - Match counters up/down, both eight means regulated
// - Three consecutive sign changes means regulated
// - No modulation: one current per phase
// - Modulation: two parts, own currents
// - Currents are six-bit step codes
`include "agts_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module agts_top #(
    parameter TW = 8 // Phase timer width
) (
    input wire REF_CLK, // Bridge clock, 100 MHz
    input wire ARST_N, // Async reset, low active
    input wire CLK_EN, // Freezes all state when low
    input wire PSEL, // APB select
    input wire PENABLE, // APB enable
    input wire PWRITE, // APB direction
    input wire [7:0] PADDR, // APB byte address
    input wire [31:0] PWDATA, // APB write data
    output reg [31:0] PRDATA, // APB read data
    output reg PREADY, // APB ready
    output reg PSLVERR, // APB error, unmapped
    input wire PWM_IN, // Mapped PWM input
    input wire SN_BELOW_LOW, // Switch node under low threshold
    input wire SN_ABOVE_HIGH, // Switch node over high threshold
    input wire TON_VALID, // Turn-on delay result strobe
    input wire TON_EQUAL, // Turn-on delay equals target
    output reg HS_SRC, // High-side gate sourcing
    output reg HS_SNK, // High-side gate sinking
    output reg [5:0] HS_CUR, // High-side gate current step
    output reg LS_SRC, // Low-side gate sourcing
    output reg LS_SNK, // Low-side gate sinking
    output reg [5:0] LS_CUR, // Low-side gate current step
    output reg REG_FLAG // Delay in regulation flag
);
// ==========================================
// States
localparam [7:0] S_OFF = 8'h01;
localparam [7:0] S_CCON = 8'h02;
localparam [7:0] S_PCHG = 8'h04;
localparam [7:0] S_ON = 8'h08;
localparam [7:0] S_SYM = 8'h10;
localparam [7:0] S_PDCHG = 8'h20;
localparam [7:0] S_DCHG = 8'h40;
localparam [7:0] S_FWON = 8'h80;
// ==========================================
// Registers
reg [7:0] ctrl_q;
reg [31:0] curr_q;
reg [31:0] time_q;
reg [15:0] tgt_q;
reg [15:0] time2_q;
reg [7:0] st_q, st_d;
reg [TW-1:0] ph_q, ph_d;
reg [TW-1:0] cc_q, cc_d;
reg cc_run_q, cc_run_d;
reg [TW-1:0] meas_q, meas_d;
reg meas_run_q, meas_run_d;
reg [TW-1:0] eff_q;
reg [5:0] pd_q;
reg [1:0] hist_q;
reg [3:0] on_cnt_q;
reg [3:0] off_cnt_q;
reg [1:0] chg_q;
reg last_sgn_q;
reg pwm_q;
reg done_q, done_d;
wire [1:0] mode = ctrl_q[`AGTS_MODE_LO+1:`AGTS_MODE_LO];
wire adapt = mode[1];
wire filt = ctrl_q[`AGTS_FILT_BIT];
wire step2 = ctrl_q[`AGTS_STEP_BIT];
wire afw = ctrl_q[`AGTS_AFW_BIT];
wire tm_en = ctrl_q[`AGTS_TM_BIT];
wire map_ls = ctrl_q[`AGTS_MAPLS_BIT];
wire [5:0] init_cur = curr_q[5:0];
wire [5:0] max_cur = curr_q[13:8];
wire [5:0] dchg_cur = curr_q[21:16];
wire [5:0] fw_cur = curr_q[29:24];
wire [TW-1:0] t_fwcc = time_q[TW-1:0];
wire [TW-1:0] t_acc = time_q[TW+7:8];
wire [TW-1:0] t_pd = time_q[TW+15:16];
wire [TW-1:0] t_vds = time_q[TW+23:24];
wire [TW-1:0] t_pc = time2_q[TW-1:0];
wire [5:0] part2_cur = time2_q[13:8];
wire [TW-1:0] t_off_tgt = tgt_q[TW-1:0];
wire node_off = map_ls ? SN_ABOVE_HIGH : SN_BELOW_LOW;
wire node_on = map_ls ? SN_BELOW_LOW : SN_ABOVE_HIGH;
wire pwm_rise = PWM_IN & ~pwm_q;
wire pwm_fall = ~PWM_IN & pwm_q;
// ==========================================
// APB slave
wire apb_acc = PSEL & PENABLE & ~PREADY;
wire apb_wr = apb_acc & PWRITE;
wire hit = (PADDR == `AGTS_OFF_CTRL) || (PADDR == `AGTS_OFF_CURR) ||
    (PADDR == `AGTS_OFF_TIME) || (PADDR == `AGTS_OFF_TGT) ||
    (PADDR == `AGTS_OFF_TIME2) || (PADDR == `AGTS_OFF_STAT);
wire en_load = apb_wr && (PADDR == `AGTS_OFF_CTRL) &&
    PWDATA[`AGTS_EN_BIT];
reg [31:0] rd_mux;
always @* begin
    rd_mux = 32'h0000_0000;
    if (PADDR == `AGTS_OFF_CTRL) begin
        rd_mux[7:0] = ctrl_q;
    end else if (PADDR == `AGTS_OFF_CURR) begin
        rd_mux = curr_q;
    end else if (PADDR == `AGTS_OFF_TIME) begin
        rd_mux = time_q;
    end else if (PADDR == `AGTS_OFF_TGT) begin
        rd_mux[15:0] = tgt_q;
    end else if (PADDR == `AGTS_OFF_TIME2) begin
        rd_mux[15:0] = time2_q;
    end else if (PADDR == `AGTS_OFF_STAT) begin
        rd_mux[TW-1:0] = eff_q;
        rd_mux[13:8] = pd_q;
        rd_mux[16] = REG_FLAG;
        rd_mux[31:24] = st_q;
    end
end
always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
        PRDATA <= 32'h0000_0000;
        ctrl_q <= `AGTS_CTRL_RST;
        curr_q <= `AGTS_CURR_RST;
        time_q <= `AGTS_TIME_RST;
        tgt_q <= `AGTS_TGT_RST;
        time2_q <= `AGTS_TIME2_RST;
    end else if (CLK_EN) begin
        PREADY <= apb_acc;
        PSLVERR <= apb_acc & ~hit;
        if (apb_acc && !PWRITE) begin
            PRDATA <= rd_mux;
        end
        if (apb_wr) begin
            if (PADDR == `AGTS_OFF_CTRL) begin
                ctrl_q <= PWDATA[7:0];
            end else if (PADDR == `AGTS_OFF_CURR) begin
                curr_q <= PWDATA & 32'h3f3f_3f3f;
            end else if (PADDR == `AGTS_OFF_TIME) begin
                time_q <= PWDATA;
            end else if (PADDR == `AGTS_OFF_TGT) begin
                tgt_q <= PWDATA[15:0];
            end else if (PADDR == `AGTS_OFF_TIME2) begin
                time2_q <= PWDATA[15:0] & 16'h3fff;
            end
        end
    end
end
// ==========================================
// Phase sequencer
// Counters tick once per bridge clock
always @* begin
    st_d = st_q;
    ph_d = ph_q + 1'b1;
    cc_d = cc_q;
    cc_run_d = cc_run_q;
    meas_d = meas_q;
    meas_run_d = meas_run_q;
    done_d = 1'b0;
    if (cc_run_q) begin
        cc_d = cc_q + 1'b1;
    end
    if (meas_run_q) begin
        if (node_off || (&meas_q)) begin
            meas_run_d = 1'b0;
            done_d = 1'b1;
        end else begin
            meas_d = meas_q + 1'b1;
        end
    end
    case (st_q)
        S_OFF, S_FWON: begin
            if (st_q == S_FWON && ph_q >= t_vds) begin
                st_d = S_OFF;
            end
            if (pwm_rise && ctrl_q[`AGTS_EN_BIT]) begin
                ph_d = {TW{1'b0}};
                st_d = afw ? S_CCON : S_PCHG;
            end
        end
        S_CCON: begin
            if (ph_q >= t_fwcc) begin
                st_d = S_PCHG;
                ph_d = {TW{1'b0}};
            end
        end
        S_PCHG: begin
            if (ph_q >= t_pc) begin
                st_d = S_ON;
                ph_d = {TW{1'b0}};
            end
        end
        S_ON: begin
            if (pwm_fall) begin
                st_d = S_SYM;
                ph_d = {TW{1'b0}};
            end
        end
        S_SYM: begin
            if (ph_q >= t_fwcc) begin
                st_d = S_PDCHG;
                ph_d = {TW{1'b0}};
                cc_run_d = 1'b1;
                cc_d = {TW{1'b0}};
                meas_run_d = 1'b1;
                meas_d = {TW{1'b0}};
            end
        end
        S_PDCHG: begin
            if (ph_q >= t_pd) begin
                st_d = S_DCHG;
                ph_d = {TW{1'b0}};
            end
        end
        default: begin
            if (cc_q >= t_acc) begin
                cc_run_d = 1'b0;
                ph_d = {TW{1'b0}};
                st_d = afw ? S_FWON : S_OFF;
            end
        end
    endcase
    if (!ctrl_q[`AGTS_EN_BIT]) begin
        st_d = S_OFF;
        cc_run_d = 1'b0;
    end
end
// ==========================================
// Gate drive
reg act_src, act_snk, fw_src, fw_snk;
reg [5:0] act_cur, fw_i;
always @* begin
    act_src = 1'b0;
    act_snk = 1'b1;
    act_cur = dchg_cur;
    fw_src = 1'b0;
    fw_snk = 1'b1;
    fw_i = fw_cur;
    case (st_q)
        S_PCHG: begin
            act_src = 1'b1;
            act_snk = 1'b0;
            act_cur = (tm_en && ph_q >= (t_pc >> 1)) ? part2_cur : init_cur;
        end
        S_ON, S_SYM: begin
            act_src = 1'b1;
            act_snk = 1'b0;
            act_cur = max_cur;
        end
        S_PDCHG: begin
            act_cur = (tm_en && ph_q >= (t_pd >> 1)) ? part2_cur : pd_q;
        end
        S_FWON: begin
            if (node_off) begin
                fw_src = 1'b1;
                fw_snk = 1'b0;
            end
        end
        default: begin
            act_cur = dchg_cur;
        end
    endcase
    if (!afw) begin
        fw_src = 1'b0;
        fw_snk = 1'b1;
    end
end
// ==========================================
// Adaptation and regulation
wire too_long = eff_q > t_off_tgt;
wire too_short = eff_q < t_off_tgt;
wire [6:0] up_v = {1'b0, pd_q} + (step2 ? 7'h02 : 7'h01);
wire [6:0] dn_v = {1'b0, pd_q} - (step2 ? 7'h02 : 7'h01);
reg [5:0] pd_next;
reg do_up, do_dn;
always @* begin
    do_up = too_long;
    do_dn = too_short;
    if (filt) begin
        do_up = too_long & hist_q[1];
        do_dn = too_short & hist_q[0];
    end
    pd_next = pd_q;
    if (do_up) begin
        pd_next = (up_v > {1'b0, max_cur}) ? max_cur : up_v[5:0];
    end else if (do_dn) begin
        pd_next = (dn_v[6] || dn_v[5:0] < `AGTS_CUR_MIN) ? `AGTS_CUR_MIN : dn_v[5:0];
    end
    if (pd_next > max_cur) begin
        pd_next = max_cur;
    end
end
reg eval_q;
wire off_eq = eff_q == t_off_tgt;
always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        st_q <= S_OFF;
        ph_q <= {TW{1'b0}};
        cc_q <= {TW{1'b0}};
        cc_run_q <= 1'b0;
        meas_q <= {TW{1'b0}};
        meas_run_q <= 1'b0;
        eff_q <= {TW{1'b0}};
        done_q <= 1'b0;
        eval_q <= 1'b0;
        pd_q <= `AGTS_CUR_MIN;
        hist_q <= 2'b00;
        on_cnt_q <= 4'h0;
        off_cnt_q <= 4'h0;
        chg_q <= 2'b00;
        last_sgn_q <= 1'b0;
        pwm_q <= 1'b0;
        REG_FLAG <= 1'b0;
        HS_SRC <= 1'b0;
        HS_SNK <= 1'b1;
        HS_CUR <= 6'h00;
        LS_SRC <= 1'b0;
        LS_SNK <= 1'b1;
        LS_CUR <= 6'h00;
    end else if (CLK_EN) begin
        pwm_q <= PWM_IN;
        st_q <= st_d;
        ph_q <= ph_d;
        cc_q <= cc_d;
        cc_run_q <= cc_run_d;
        meas_q <= meas_d;
        meas_run_q <= meas_run_d;
        done_q <= done_d;
        eval_q <= done_q;
        if (done_q) begin
            eff_q <= meas_q;
        end
        if (en_load) begin
            pd_q <= (init_cur < max_cur) ? init_cur : max_cur;
            hist_q <= 2'b00;
        end else if (eval_q && adapt) begin
            pd_q <= pd_next;
            hist_q <= {too_long, too_short};
        end
        if (eval_q) begin
            if (off_eq) begin
                off_cnt_q <= (&off_cnt_q) ? off_cnt_q : off_cnt_q + 4'h1;
            end else if (off_cnt_q != 4'h0) begin
                off_cnt_q <= off_cnt_q - 4'h1;
            end
            if (off_eq) begin
                chg_q <= 2'b00;
            end else begin
                last_sgn_q <= too_long;
                if (too_long != last_sgn_q) begin
                    chg_q <= (chg_q == `AGTS_SIGN_CHG) ? chg_q : chg_q + 2'b01;
                end else begin
                    chg_q <= 2'b00;
                end
            end
        end
        if (TON_VALID) begin
            if (TON_EQUAL) begin
                on_cnt_q <= (&on_cnt_q) ? on_cnt_q : on_cnt_q + 4'h1;
            end else if (on_cnt_q != 4'h0) begin
                on_cnt_q <= on_cnt_q - 4'h1;
            end
        end
        REG_FLAG <= adapt && ((on_cnt_q >= `AGTS_REG_CNT &&
            off_cnt_q >= `AGTS_REG_CNT) || chg_q == `AGTS_SIGN_CHG);
        HS_SRC <= map_ls ? fw_src : act_src;
        HS_SNK <= map_ls ? fw_snk : act_snk;
        HS_CUR <= map_ls ? fw_i : act_cur;
        LS_SRC <= map_ls ? act_src : fw_src;
        LS_SNK <= map_ls ? act_snk : fw_snk;
        LS_CUR <= map_ls ? act_cur : fw_i;
    end
end
endmodule // agts_top
`default_nettype wire

// >>> tb/agts_checker.sv
// Purpose: port checks of the gate turn-off sequencer
// Assumes: control word snooped from APB writes, timing word at reset
// Notes: one clock domain
`include "agts_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module agts_checker (
    input wire logic REF_CLK, // Clock
    input wire logic ARST_N, // Reset
    input wire logic CLK_EN, // Clock enable
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic [7:0] PADDR, // APB address
    input wire logic [31:0] PWDATA, // APB write data
    input wire logic PREADY, // APB ready
    input wire logic PSLVERR, // APB error
    input wire logic PWM_IN, // PWM input
    input wire logic HS_SRC, // High-side source
    input wire logic HS_SNK, // High-side sink
    input wire logic LS_SRC, // Low-side source
    input wire logic REG_FLAG // Regulation flag
);
    // ==========================================
    // Snooped configuration
    // Reset symmetrization time; the bench never rewrites it
    localparam logic [7:0] T_FW = 8'h04;
    logic [7:0] ctrl_q;
    logic [7:0] fall_q;
    logic pwm_q;
    wire logic take = PSEL && PENABLE && !PREADY && CLK_EN;
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_q <= `AGTS_CTRL_RST;
            fall_q <= 8'hff;
            pwm_q <= 1'b0;
        end else begin
            if (take && PWRITE && PADDR == `AGTS_OFF_CTRL)
                ctrl_q <= PWDATA[7:0];
            // Saturates so a long idle never aliases a fresh edge
            if (pwm_q && !PWM_IN)
                fall_q <= 8'h00;
            else if (fall_q != 8'hff)
                fall_q <= fall_q + 8'h01;
            pwm_q <= PWM_IN;
        end
    end
    // ==========================================
    // Assertions
    default clocking dc @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    apb_answer_a: assert property (take |=> PREADY) else $error("no ready after access");
    ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held too long");
    slverr_ready_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
    disabled_off_a: assert property (!ctrl_q[5] && !$past(ctrl_q[5], 3) |-> !HS_SRC && !LS_SRC)
        else $error("gate on while disabled");
    no_shoot_a: assert property (!(HS_SRC && LS_SRC)) else $error("both switches sourced");
    passive_fw_a: assert property (!$past(ctrl_q[4]) && !$past(ctrl_q[7]) |-> !LS_SRC)
        else $error("complementary switch on");
    sym_delay_a: assert property ($rose(HS_SNK) && ctrl_q[5] && !ctrl_q[7] |->
        fall_q > T_FW && fall_q < T_FW + 8'h07) else $error("turn-off start off time");
    flag_mode_a: assert property (REG_FLAG |-> $past(ctrl_q[1])) else $error("flag outside adaptive mode");
    cover property (PREADY && PSLVERR);
    cover property ($rose(LS_SRC));
    cover property ($rose(REG_FLAG));
endmodule // agts_checker
bind agts_top agts_checker u_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CLK_EN(CLK_EN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PWM_IN(PWM_IN), .HS_SRC(HS_SRC), .HS_SNK(HS_SNK), .LS_SRC(LS_SRC),
    .REG_FLAG(REG_FLAG));
`default_nettype wire

// >>> tb/agts_fet_model.sv
// Purpose: switch node of a half-bridge driven from the high side
// Assumes: node follows the high-side gate
// Notes: fall delay set at run time for slow or fast switching
`timescale 1ns/1ps
`default_nettype none
module agts_fet_model (
    input wire logic clk, // Bridge clock
    input wire logic rst_n, // Reset, low active
    input wire logic gate_src, // Gate sourced
    input wire logic gate_snk, // Gate sunk
    input wire logic [7:0] dly, // Fall delay in cycles
    output logic node_low, // Node under low threshold
    output logic node_high // Node over high threshold
);
    logic hi_q;
    logic [7:0] cnt_q;
    assign node_high = hi_q;
    assign node_low = !hi_q;
    // Node lags the sink so the turn-off delay is measurable
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (gate_src) begin
            hi_q <= 1'b1;
            cnt_q <= 8'h00;
        end else if (gate_snk && hi_q) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q + 8'h01 >= dly)
                hi_q <= 1'b0;
        end
    end
endmodule // agts_fet_model
`default_nettype wire

// >>> tb/agts_tb.sv
// Purpose: self-checking bench of the gate turn-off sequencer
// Assumes: high-side mapping, turn-on result input driven only in s_count
// Notes: adaptation judged through the status word
`include "agts_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, arst_n, psel, penable, pwrite, pwm, err, ls_seen;
    logic clk_en, ton_vld, ton_eq, hs_snk_q;
    logic [3:0] snk_cnt;
    logic [5:0] cur_a, cur_b;
    logic pready, pslverr, sn_lo, sn_hi, hs_src, hs_snk, ls_src, ls_snk, reg_flag;
    logic [7:0] paddr, dly;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] hs_cur, ls_cur;
    int error_cnt, n_tests;
    agts_top #(.TW(8)) uut (.REF_CLK(clk), .ARST_N(arst_n), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PWM_IN(pwm), .SN_BELOW_LOW(sn_lo), .SN_ABOVE_HIGH(sn_hi),
        .TON_VALID(ton_vld), .TON_EQUAL(ton_eq), .HS_SRC(hs_src), .HS_SNK(hs_snk), .HS_CUR(hs_cur),
        .LS_SRC(ls_src), .LS_SNK(ls_snk), .LS_CUR(ls_cur), .REG_FLAG(reg_flag));
    agts_fet_model u_fet (.clk(clk), .rst_n(arst_n), .gate_src(hs_src), .gate_snk(hs_snk), .dly(dly),
        .node_low(sn_lo), .node_high(sn_hi));
    // ==========================================
    // Shared tasks
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            close_out();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // Idle edge so a following call never re-raises psel in this step
            @(posedge clk);
        end
    endtask
    task automatic cmp_cur(input logic [5:0] exp);
        apb(1'b0, `AGTS_OFF_STAT, 32'h0);
        cmp("pd current", {26'h0, exp}, {26'h0, rd[13:8]});
    endtask
    task automatic pwm_cycle(input logic [7:0] d);
        dly <= d;
        pwm <= 1'b1;
        repeat (40) @(posedge clk);
        pwm <= 1'b0;
        repeat (80) @(posedge clk);
    endtask
    task automatic load(input logic [31:0] curr, input logic [31:0] ctrl);
        apb(1'b1, `AGTS_OFF_CURR, curr);
        apb(1'b1, `AGTS_OFF_CTRL, ctrl);
    endtask
    // ==========================================
    // Scenarios
    task automatic s_regs;
        cmp("flag reset", 32'h0, {31'h0, reg_flag});
        apb(1'b0, `AGTS_OFF_CURR, 32'h0);
        cmp("curr reset", `AGTS_CURR_RST, rd);
        apb(1'b0, `AGTS_OFF_TIME, 32'h0);
        cmp("time reset", `AGTS_TIME_RST, rd);
        apb(1'b0, 8'h40, 32'h0);
        cmp("unmapped error", 32'h1, {31'h0, err});
        cmp("unmapped data", 32'h0, rd);
    endtask
    task automatic s_adapt;
        load(32'h0000_1030, 32'h22);
        cmp_cur(6'h10);
        apb(1'b1, `AGTS_OFF_CURR, 32'h0000_1005);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `AGTS_OFF_CTRL, {30'h8, m[1:0]});
            pwm_cycle(8'd24);
            cmp_cur(m > 1 ? 6'h06 : 6'h05);
        end
        cmp("eff long", 32'h1, {31'h0, rd[7:0] > 8'h10});
        pwm_cycle(8'd2);
        cmp_cur(6'h05);
    endtask
    task automatic s_step;
        load(32'h0000_1211, 32'h2a);
        pwm_cycle(8'd24);
        cmp_cur(6'h12);
        pwm_cycle(8'd2);
        cmp_cur(6'h10);
        load(32'h0000_1201, 32'h2a);
        pwm_cycle(8'd2);
        cmp_cur(6'h00);
    endtask
    task automatic s_filter;
        load(32'h0000_1005, 32'h26);
        pwm_cycle(8'd24);
        cmp_cur(6'h05);
        cmp("pd part one", 32'h5, {26'h0, cur_a});
        cmp("pd part two", 32'h5, {26'h0, cur_b});
        pwm_cycle(8'd24);
        cmp_cur(6'h06);
        // Frozen cycle: a live design would step the current up
        clk_en <= 1'b0;
        pwm_cycle(8'd24);
        clk_en <= 1'b1;
        cmp_cur(6'h06);
        apb(1'b1, `AGTS_OFF_CTRL, 32'h66);
        pwm_cycle(8'd24);
        cmp("tm part one", 32'h5, {26'h0, cur_a});
        cmp("tm part two", 32'h10, {26'h0, cur_b});
    endtask
    task automatic s_count;
        ton_eq <= 1'b1;
        apb(1'b1, `AGTS_OFF_CTRL, 32'h22);
        // Fall delay 15 gives a measured delay equal to the target
        for (int k = 0; k < 8; k++) begin
            ton_vld <= 1'b1;
            @(posedge clk);
            ton_vld <= 1'b0;
            pwm_cycle(8'd15);
            if (k == 6)
                cmp("flag seven", 32'h0, {31'h0, reg_flag});
        end
        cmp("flag eight", 32'h1, {31'h0, reg_flag});
    endtask
    task automatic s_afw;
        cmp("ls passive", 32'h0, {31'h0, ls_seen});
        apb(1'b1, `AGTS_OFF_CTRL, 32'h32);
        pwm_cycle(8'd24);
        cmp("ls freewheel", 32'h1, {31'h0, ls_seen});
        for (int k = 0; k < 4; k++)
            pwm_cycle(k[0] ? 8'd24 : 8'd2);
        cmp("flag", 32'h1, {31'h0, reg_flag});
        apb(1'b0, `AGTS_OFF_STAT, 32'h0);
        cmp("flag status", 32'h1, {31'h0, rd[16]});
    endtask
    // ==========================================
    // Clock, watchdog and main sequence
    always @(posedge clk)
        if (!arst_n)
            ls_seen <= 1'b0;
        else if (ls_src === 1'b1)
            ls_seen <= 1'b1;
    // High-side current at first and seventh pre-discharge cycle
    always @(posedge clk) begin
        hs_snk_q <= hs_snk;
        if (hs_snk && !hs_snk_q) begin
            snk_cnt <= 4'h0;
            cur_a <= hs_cur;
        end else if (snk_cnt != 4'hf) begin
            snk_cnt <= snk_cnt + 4'h1;
        end
        if (snk_cnt == 4'h5)
            cur_b <= hs_cur;
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pwm = 1'b0;
        dly = 8'd24;
        clk_en = 1'b1;
        ton_vld = 1'b0;
        ton_eq = 1'b0;
        error_cnt = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        s_regs();
        s_adapt();
        s_step();
        s_filter();
        s_afw();
        s_count();
        close_out();
    end
endmodule // tb
`default_nettype wire
